/* File: dv/sbc_board_monitor.sv */
// Concurrent checks on the ports of the board top
`timescale 1ns/100ps
`default_nettype none
module sbc_board_monitor
    import sbc_pkg::*;
#(
    parameter int WDT_CYCLES = 50
) (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire sbc_bus_t    bus_i,
    input wire logic        watchdog_jumper_i,
    input wire logic        watchdog_hit_i,
    input wire logic        step_pulse_n_i,
    input wire logic [7:0]  pg_rd_data_i,
    input wire logic [7:0]  bus_rd_data_o,
    input wire logic        bus_rd_valid_o,
    input wire sbc_pg_req_t pg_req_o,
    input wire logic        pulse_gen_reset_n_o,
    input wire logic        driver_output_enable_pin_n_o,
    input wire logic        half_step_select_o,
    input wire logic        single_phase_select_o,
    input wire logic        winding_a_n_o,
    input wire logic        winding_b_n_o,
    input wire logic        winding_c_n_o,
    input wire logic        winding_d_n_o,
    input wire logic        watchdog_out_n_o
);
    wire [3:0] wind  = {winding_a_n_o, winding_b_n_o, winding_c_n_o, winding_d_n_o};
    wire [2:0] ctl   = {single_phase_select_o, half_step_select_o, driver_output_enable_pin_n_o};
    wire       blank = ctl[0] | (ctl[2] & ctl[1]);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    pg_read_a: assert property (pg_req_o.rd |=> bus_rd_valid_o
        && bus_rd_data_o == $past(pg_rd_data_i)) else $error("generator read data lost");
    blank_out_a: assert property (blank [*2] |-> wind == 4'hF)
        else $error("windings driven while blanked");
    step_hold_a: assert property ((step_pulse_n_i && $stable(ctl)) [*4] |-> $stable(wind))
        else $error("windings moved without a step");
    step_move_a: assert property ($fell(step_pulse_n_i) && !blank && $stable(ctl)
        |-> ##[1:2] $changed(wind)) else $error("step strobe did not advance");
    wdt_off_a: assert property (!watchdog_jumper_i [*3] |-> watchdog_out_n_o)
        else $error("watchdog fired while disabled");
    wdt_hit_a: assert property (watchdog_hit_i |-> ##[1:2] watchdog_out_n_o)
        else $error("watchdog output not released by hit");
    wdt_pg_a: assert property (!watchdog_out_n_o |=> !pulse_gen_reset_n_o)
        else $error("watchdog did not reset generator");
    bus_rst_a: assert property (bus_i.bus_reset |-> ##[1:2] !pulse_gen_reset_n_o)
        else $error("bus reset did not reset generator");
endmodule : sbc_board_monitor
bind sbc_board sbc_board_monitor #(.WDT_CYCLES(WDT_CYCLES)) u_monitor (.*);
`default_nettype wire

/* File: dv/sbc_host_model.sv */
// Host controller model on the expansion bus
`timescale 1ns/100ps
`default_nettype none
module sbc_host_model
    import sbc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i,
    output sbc_bus_t        bus_o
);
    int seed = 32'h605D;
    initial bus_o = '0;
    // One strobe; a released bus shows the inverse of the last byte
    task automatic cyc(input logic [4:0] s, input logic [7:0] d);
        bus_o <= {d, s};
        @(posedge core_clk_i);
        bus_o <= {~d, 5'h00};
    endtask : cyc
    task automatic idle();
        repeat (3 + ($random(seed) & 1)) @(posedge core_clk_i);
    endtask : idle
    task automatic sel(input logic [3:0] j, input logic r);
        cyc(5'h10, {j, 4'hC});
        @(posedge core_clk_i);
        cyc(5'h08, {1'($random(seed)), 4'h0, r, 2'($random(seed))});
        idle();
    endtask : sel
    task automatic wr(input logic [7:0] d);
        cyc(5'h04, d);
        idle();
    endtask : wr
    task automatic rd(output logic [7:0] v);
        cyc(5'h02, 8'h00);
        for (int i = 0; i < 4 && rd_valid_i !== 1'b1; i++) @(posedge core_clk_i);
        v = rd_data_i;
    endtask : rd
endmodule : sbc_host_model
`default_nettype wire

/* File: dv/tb_stepper_board_control_logic.sv */
// Self-checking bench for the stepper board control logic
`timescale 1ns/100ps
`default_nettype none
module tb_stepper_board_control_logic
    import sbc_pkg::*;
;
    localparam int WDT = 50;
    logic        core_clk_i = 1'b0, reset_i = 1'b1, watchdog_jumper_i = 1'b0;
    logic        watchdog_hit_i = 1'b0, step_pulse_n_i = 1'b1, step_direction_i = 1'b1;
    logic        encoder_in_a_i = 1'b0, encoder_in_b_i = 1'b0;
    logic [3:0]  address_jumper_header_i = 4'h0, jmp;
    logic [7:0]  pg_rd_data_i = 8'h00, bus_rd_data_o, rd_byte, pg_exp, d;
    logic        bus_rd_valid_o, local_select_low_o, local_select_high_o, pulse_gen_reset_n_o;
    logic        indicator_light_n_o, driver_output_enable_pin_n_o, half_step_select_o;
    logic        single_phase_select_o, watchdog_out_n_o;
    logic        winding_a_n_o, winding_b_n_o, winding_c_n_o, winding_d_n_o;
    sbc_bus_t    bus_i;
    sbc_pg_req_t pg_req_o;
    int          fails = 0, comparisons = 0, seed = 32'h605D, pg_wr_n = 0;
    int          pos [3] = '{0, 0, 0};
    logic [15:0] cnt = 16'h0000, got;
    logic [1:0]  q = 2'h0, s;
    wire  [3:0]  wind = {winding_a_n_o, winding_b_n_o, winding_c_n_o, winding_d_n_o};

    sbc_board #(.WDT_CYCLES(WDT)) dut (.*);
    sbc_host_model host (.core_clk_i(core_clk_i), .rd_data_i(bus_rd_data_o),
                         .rd_valid_i(bus_rd_valid_o), .bus_o(bus_i));

    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) pg_rd_data_i <= 8'($random(seed));
    always @(posedge core_clk_i) if (pg_req_o.rd === 1'b1) pg_exp = pg_rd_data_i;
    always @(posedge core_clk_i) if (pg_req_o.wr === 1'b1) pg_wr_n++;

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic finish_test();
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // Phase tables ABCD, entry i in nibble i, four-entry lists repeated
    function automatic logic [3:0] ph(input int m, input int i);
        logic [31:0] t [3];
        t = '{32'hC936C936, 32'h6ECD9B37, 32'hEDB7EDB7};
        return t[m][i*4 +: 4];
    endfunction : ph
    function automatic logic [7:0] lv(input logic [1:0] m, input logic [1:0] sl);
        return {m, 1'b0, sl, 3'b111};
    endfunction : lv
    task automatic step(input int m, input logic dir);
        step_direction_i <= dir;
        step_pulse_n_i   <= 1'b0;
        tick(2);
        step_pulse_n_i   <= 1'b1;
        tick(3);
        if (m < 3) pos[m] = (pos[m] + (dir ? 1 : 7)) % 8;
        chk(16'(wind), m < 3 ? 16'(ph(m, pos[m])) : 16'hF);
    endtask : step
    task automatic walk(input int n);
        logic up;
        for (int k = 0; k < n; k++) begin
            up = (k < 6) ? 1'b0 : 1'($random(seed));
            q  = up ? q + 2'h1 : q - 2'h1;
            {encoder_in_a_i, encoder_in_b_i} <= {q[1], q[1] ^ q[0]};
            cnt = up ? cnt + 16'h1 : cnt - 16'h1;
            tick(QUAD_GAP_CYC);
        end
    endtask : walk
    task automatic rdcnt(output logic [15:0] v);
        host.wr(8'h2F);
        host.rd(v[15:8]);
        host.wr(8'h27);
        host.rd(v[7:0]);
    endtask : rdcnt

    initial begin
        jmp = 4'($random(seed));
        address_jumper_header_i <= jmp;
        tick(6);
        reset_i <= 1'b0;
        tick(1);
        host.sel(~jmp, 1'b1);
        host.wr(lv(2'h0, 2'h0));
        chk(16'({driver_output_enable_pin_n_o, indicator_light_n_o}), 16'h3);
        host.sel(jmp, 1'b1);
        chk(16'(indicator_light_n_o), 16'h0);
        for (int m = 0; m < 4; m++) begin
            s = 2'($random(seed));
            host.wr(lv(2'(m), s));
            chk(16'({single_phase_select_o, half_step_select_o,
                driver_output_enable_pin_n_o, local_select_high_o, local_select_low_o}),
                16'({2'(m), 1'b0, s}));
            chk(16'(wind), m < 3 ? 16'(ph(m, pos[m])) : 16'hF);
            repeat (6) step(m, 1'($random(seed)));
        end
        host.wr(8'h26);
        walk(4);
        cnt = 16'h0000;
        host.wr(8'h27);
        walk(40);
        rdcnt(got);
        chk(got, cnt);
        watchdog_jumper_i <= 1'b1;
        tick(WDT + 10);
        chk(16'({watchdog_out_n_o, pulse_gen_reset_n_o}), 16'h0);
        watchdog_hit_i <= 1'b1;
        tick(1);
        watchdog_hit_i <= 1'b0;
        watchdog_jumper_i <= 1'b0;
        tick(3);
        chk(16'(watchdog_out_n_o), 16'h1);
        rdcnt(got);
        chk(got, cnt);
        host.cyc(5'h01, 8'h00);
        tick(3);
        chk(16'({driver_output_enable_pin_n_o, local_select_high_o,
            local_select_low_o}), 16'h4);
        host.sel(jmp, 1'b1);
        host.wr(lv(2'h1, 2'h0));
        chk(16'(wind), 16'(ph(1, pos[1])));
        rdcnt(got);
        chk(got, 16'h0000);
        host.wr(8'h61);
        host.sel(~jmp, 1'b1);
        chk(16'({pulse_gen_reset_n_o, indicator_light_n_o, wind}), 16'h000F);
        host.sel(jmp, 1'b0);
        d = 8'($random(seed));
        host.wr(d);
        chk(16'(pg_req_o.data), 16'(d));
        chk(16'(pg_wr_n), 16'h0001);
        host.rd(rd_byte);
        chk(16'(rd_byte), 16'(pg_exp));
        finish_test();
    end

    initial begin
        tick(20000);
        fails++;
        finish_test();
    end
endmodule : tb_stepper_board_control_logic
`default_nettype wire

/* File: hw/sbc_board.sv */
// Top of the stepper board control logic: bus decode, latch, resets
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1: Control bits 7:6 pick mode: 00 two-phase, 01 half-step, 10 single-phase.
// R2: Forward walks single and two-phase tables in order, reverse walks them backwards.
// R3: Half-step walks eight states; every mode starts at its first state.
// R4: Winding outputs are active low; zero means the winding is on.
// R5: Direction high steps forward, low steps reverse.
// R6: Each low pulse on the step strobe advances exactly one step.
// R7: Advance on the strobe falling edge and hold between pulses.
// R8: Counter decodes A/B states and counts up or down by transition order.
// R9: Counter is sixteen bits, read by the host as two bytes.
// R10: Counter must follow input transitions up to 3 MHz.
// R11: Control latch is eight bits, write only; reads give no latch data.
// R12: Control bit 0 low holds the counter in reset, high releases it.
// R13: Control bit 1 low holds the pulse generator in reset.
// R14: Control bit 2 low lights the indicator.
// R15: Control bit 5 low enables winding outputs; high turns all off.
// R16: Bits 3 and 4 drive pulse generator selects; bit 3 picks counter byte.
// R17: Bit 3 low reads counter low byte, high reads high byte.
// R18: Board answers address abcd1100 then x0000Rxx; abcd from jumpers.
// R19: R zero goes to pulse generator; R one reads counter, writes latch.
// R20: Indicator also lights while the board is addressed.
// R21: Power-up hard resets pulse generator and counter.
// R22: Host writes the latch before using anything else.
// R23: Bus reset pulses generator and counter resets; latch and sequencer kept.
// R24: Enabled watchdog timeout drives watchdog output low, resetting generator.
// R25: Host services watchdog within 1.5 s; timeout leaves counter alone.
module sbc_board
    import sbc_pkg::*;
#(
    parameter int WDT_CYCLES = WDT_TIMEOUT_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire sbc_bus_t    bus_i,
    input  wire logic [3:0]  address_jumper_header_i,
    input  wire logic        watchdog_jumper_i,
    input  wire logic        watchdog_hit_i,
    input  wire logic        step_pulse_n_i,
    input  wire logic        step_direction_i,
    input  wire logic        encoder_in_a_i,
    input  wire logic        encoder_in_b_i,
    input  wire logic [7:0]  pg_rd_data_i,
    output logic [7:0]       bus_rd_data_o,
    output logic             bus_rd_valid_o,
    output sbc_pg_req_t      pg_req_o,
    output logic             local_select_low_o,
    output logic             local_select_high_o,
    output logic             pulse_gen_reset_n_o,
    output logic             indicator_light_n_o,
    output logic             driver_output_enable_pin_n_o,
    output logic             half_step_select_o,
    output logic             single_phase_select_o,
    output logic             winding_a_n_o,
    output logic             winding_b_n_o,
    output logic             winding_c_n_o,
    output logic             winding_d_n_o,
    output logic             watchdog_out_n_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sbc_ctrl_t             ctrl_q;
    sbc_addr_st_t          st_q;
    sbc_addr_st_t          st_d;
    logic                  r_sel_q;
    logic                  step_n_q;
    logic [3:0]            winding_q;
    logic [7:0]            rd_data_q;
    logic                  rd_valid_q;
    logic                  pg_rd_wait_q;
    sbc_pg_req_t           pg_req_q;
    logic                  pg_reset_n_q;
    logic                  light_n_q;
    logic [WDT_CNT_W-1:0]  wdt_cnt_q;
    logic                  wdt_fired_q;
    logic                  wdt_out_n_q;
    logic [7:0]            low_hold_q;
    logic                  low_held_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [3:0] a1_board = bus_i.data[7:4];
    wire [3:0] a1_code  = bus_i.data[3:0];
    wire [3:0] a2_zero  = bus_i.data[6:3];
    wire       a1_match = (a1_code == ADDR_BOARD_CODE)
                       && (a1_board == address_jumper_header_i); // R18
    wire       a2_match = (a2_zero == ADDR2_ZERO_VAL); // R18
    wire       selected = (st_q == ST_SEL);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (bus_i.addr_first && a1_match) begin
                    st_d = ST_HALF;
                end
            end
            ST_HALF: begin
                if (bus_i.addr_first) begin
                    st_d = a1_match ? ST_HALF : ST_IDLE;
                end else if (bus_i.addr_second) begin
                    st_d = a2_match ? ST_SEL : ST_IDLE; // R18
                end
            end
            ST_SEL: begin
                if (bus_i.addr_first) begin
                    st_d = a1_match ? ST_HALF : ST_IDLE;
                end else if (bus_i.addr_second) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (bus_i.bus_reset) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_q    <= ST_IDLE;
            r_sel_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == ST_HALF && bus_i.addr_second && a2_match) begin
                r_sel_q <= bus_i.data[ADDR2_R_BIT]; // R19
            end
        end
    end

    // ------------------------------------------------------------
    // Access steering
    // ------------------------------------------------------------
    wire wr_latch = selected && bus_i.wr && r_sel_q; // R19
    wire rd_count = selected && bus_i.rd && r_sel_q; // R19
    wire wr_pg    = selected && bus_i.wr && !r_sel_q; // R19
    wire rd_pg    = selected && bus_i.rd && !r_sel_q; // R19

    // Bus reset leaves the latch alone; only power-up restores it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_q <= sbc_ctrl_t'(CTRL_RESET_VAL);
        end else if (wr_latch) begin
            ctrl_q <= sbc_ctrl_t'(bus_i.data); // R11 R23
        end
    end

    wire sbc_mode_t mode_w = sbc_mode_t'({ctrl_q.single_phase_sel,
                                          ctrl_q.half_step_sel}); // R1

    // ------------------------------------------------------------
    // Quadrature counter
    // ------------------------------------------------------------
    wire             cnt_clear = reset_i || bus_i.bus_reset
                              || !ctrl_q.counter_reset_n; // R12 R21 R23
    wire [CNT_W-1:0] count_w;

    sbc_quad_counter u_counter (
        .core_clk_i (core_clk_i),
        .clear_i    (cnt_clear),
        .enc_a_i    (encoder_in_a_i),
        .enc_b_i    (encoder_in_b_i),
        .count_o    (count_w)
    );

    // High byte read freezes the low byte so the pair stays coherent
    wire       rd_high   = rd_count && ctrl_q.local_select_low; // R16 R17
    wire       rd_low    = rd_count && !ctrl_q.local_select_low; // R17
    wire [7:0] low_byte  = low_held_q ? low_hold_q : count_w[7:0];
    wire [7:0] cnt_byte  = rd_high ? count_w[15:8] : low_byte; // R9 R17

    always_ff @(posedge core_clk_i) begin
        if (reset_i || cnt_clear) begin
            low_hold_q <= 8'h00;
            low_held_q <= 1'b0;
        end else if (rd_high) begin
            low_hold_q <= count_w[7:0]; // R9
            low_held_q <= 1'b1;
        end else if (rd_low) begin
            low_held_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pulse generator port and read return
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pg_req_q     <= '0;
            pg_rd_wait_q <= 1'b0;
            rd_data_q    <= 8'h00;
            rd_valid_q   <= 1'b0;
        end else begin
            pg_req_q.wr  <= wr_pg; // R19
            pg_req_q.rd  <= rd_pg; // R19
            if (wr_pg) begin
                pg_req_q.data <= bus_i.data;
            end
            pg_rd_wait_q <= rd_pg;
            rd_valid_q   <= rd_count || pg_rd_wait_q;
            if (rd_count) begin
                rd_data_q <= cnt_byte; // R11 R19
            end else if (pg_rd_wait_q) begin
                rd_data_q <= pg_rd_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    wire wdt_end = (wdt_cnt_q == WDT_CNT_W'(WDT_CYCLES - 1));

    always_ff @(posedge core_clk_i) begin
        if (reset_i || watchdog_hit_i || !watchdog_jumper_i) begin
            wdt_cnt_q   <= '0;
            wdt_fired_q <= 1'b0;
        end else if (wdt_end) begin
            wdt_fired_q <= 1'b1; // R24 R25
        end else begin
            wdt_cnt_q <= wdt_cnt_q + 28'h0000001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wdt_out_n_q <= 1'b1;
        end else begin
            wdt_out_n_q <= !(watchdog_jumper_i && wdt_fired_q); // R24
        end
    end

    // ------------------------------------------------------------
    // Pulse generator hard reset
    // ------------------------------------------------------------
    wire pg_reset_w = bus_i.bus_reset
                   || !ctrl_q.pulse_gen_reset_n
                   || !wdt_out_n_q; // R13 R23 R24

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pg_reset_n_q <= 1'b0; // R21
        end else begin
            pg_reset_n_q <= !pg_reset_w; // R13 R23 R24
        end
    end

    // ------------------------------------------------------------
    // Indicator
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            light_n_q <= 1'b1;
        end else begin
            light_n_q <= ctrl_q.indicator_off && !selected; // R14 R20
        end
    end

    // ------------------------------------------------------------
    // Step strobe and winding sequencer
    // ------------------------------------------------------------
    wire       step_fall = step_n_q && !step_pulse_n_i; // R6 R7
    wire [3:0] phase_w;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            step_n_q <= 1'b1;
        end else begin
            step_n_q <= step_pulse_n_i;
        end
    end

    // Sequencer sees power-up reset only, never the bus reset
    sbc_phase_seq u_seq (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i), // R23
        .step_i     (step_fall), // R7
        .dir_i      (step_direction_i), // R5
        .mode_i     (mode_w),
        .phase_n_o  (phase_w)
    );

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            winding_q <= PHASE_OFF;
        end else if (ctrl_q.driver_output_enable_n) begin
            winding_q <= PHASE_OFF; // R15 R4
        end else begin
            winding_q <= phase_w; // R4
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus_rd_data_o                = rd_data_q;
    assign bus_rd_valid_o               = rd_valid_q;
    assign pg_req_o                     = pg_req_q;
    assign local_select_low_o           = ctrl_q.local_select_low; // R16
    assign local_select_high_o          = ctrl_q.local_select_high; // R16
    assign pulse_gen_reset_n_o          = pg_reset_n_q;
    assign indicator_light_n_o          = light_n_q;
    assign driver_output_enable_pin_n_o = ctrl_q.driver_output_enable_n; // R15
    assign half_step_select_o           = ctrl_q.half_step_sel; // R1
    assign single_phase_select_o        = ctrl_q.single_phase_sel; // R1
    assign winding_a_n_o                = winding_q[3];
    assign winding_b_n_o                = winding_q[2];
    assign winding_c_n_o                = winding_q[1];
    assign winding_d_n_o                = winding_q[0];
    assign watchdog_out_n_o             = wdt_out_n_q;

endmodule : sbc_board
`default_nettype wire

/* File: hw/sbc_phase_seq.sv */
// Winding phase sequencer with one position per step mode
`timescale 1ns/100ps
`default_nettype none
module sbc_phase_seq
    import sbc_pkg::*;
(
    input  wire logic      core_clk_i,
    input  wire logic      reset_i,
    input  wire logic      step_i,
    input  wire logic      dir_i,
    input  wire sbc_mode_t mode_i,
    output logic [3:0]     phase_n_o
);

    // ------------------------------------------------------------
    // Per-mode position counters
    // ------------------------------------------------------------
    generate
        for (genvar m = 0; m < 3; m++) begin : g_mode
            localparam sbc_mode_t  MD   = sbc_mode_t'(m);
            localparam logic [2:0] LAST = (MD == MODE_HALF) ? SEQ8_LAST : SEQ4_LAST;
            logic [2:0] idx_q;
            wire        hit = step_i && (mode_i == MD);
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    idx_q <= SEQ_FIRST; // R3
                end else if (hit) begin // R6
                    if (dir_i) begin // R5
                        idx_q <= (idx_q == LAST) ? SEQ_FIRST : idx_q + 3'h1; // R2 R3
                    end else begin
                        idx_q <= (idx_q == SEQ_FIRST) ? LAST : idx_q - 3'h1; // R2 R3
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Table lookup for the active mode
    // ------------------------------------------------------------
    wire [3:0] two_w    = SEQ_TWO[g_mode[0].idx_q[1:0]];
    wire [3:0] half_w   = SEQ_HALF[g_mode[1].idx_q];
    wire [3:0] single_w = SEQ_SINGLE[g_mode[2].idx_q[1:0]];

    assign phase_n_o = (mode_i == MODE_TWO)    ? two_w    :
                       (mode_i == MODE_HALF)   ? half_w   :
                       (mode_i == MODE_SINGLE) ? single_w : PHASE_OFF; // R1

endmodule : sbc_phase_seq
`default_nettype wire

/* File: hw/sbc_pkg.sv */
// Shared constants and types for the stepper board control logic
`default_nettype none
package sbc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int  CLK_FREQ_HZ     = 100_000_000;
    localparam real WDT_TIMEOUT_S   = 1.5;
    localparam int  WDT_TIMEOUT_CYC = $rtoi(WDT_TIMEOUT_S * CLK_FREQ_HZ);
    localparam int  WDT_CNT_W       = 28;
    localparam int  QUAD_MAX_HZ     = 3_000_000;
    localparam int  QUAD_GAP_CYC    = CLK_FREQ_HZ / QUAD_MAX_HZ;

    // ------------------------------------------------------------
    // Bus address decode
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_BOARD_CODE = 4'hC;
    localparam logic [3:0] ADDR2_ZERO_VAL  = 4'h0;
    localparam int         ADDR2_R_BIT     = 2;

    // ------------------------------------------------------------
    // Control latch
    // ------------------------------------------------------------
    typedef struct packed {
        logic single_phase_sel;
        logic half_step_sel;
        logic driver_output_enable_n;
        logic local_select_high;
        logic local_select_low;
        logic indicator_off;
        logic pulse_gen_reset_n;
        logic counter_reset_n;
    } sbc_ctrl_t;

    localparam logic [7:0] CTRL_RESET_VAL = 8'h3F;

    typedef enum logic [1:0] {
        MODE_TWO    = 2'h0,
        MODE_HALF   = 2'h1,
        MODE_SINGLE = 2'h2,
        MODE_UNDEF  = 2'h3
    } sbc_mode_t;

    // ------------------------------------------------------------
    // Phase tables, ABCD with A in bit 3, entry 0 is the first state
    // ------------------------------------------------------------
    localparam logic [3:0][3:0] SEQ_SINGLE = {4'hE, 4'hD, 4'hB, 4'h7};
    localparam logic [3:0][3:0] SEQ_TWO    = {4'hC, 4'h9, 4'h3, 4'h6};
    localparam logic [7:0][3:0] SEQ_HALF   = {4'h6, 4'hE, 4'hC, 4'hD,
                                              4'h9, 4'hB, 4'h3, 4'h7};
    localparam logic [3:0]      PHASE_OFF  = 4'hF;
    localparam logic [2:0]      SEQ_FIRST  = 3'h0;
    localparam logic [2:0]      SEQ4_LAST  = 3'h3;
    localparam logic [2:0]      SEQ8_LAST  = 3'h7;

    // ------------------------------------------------------------
    // Counter and bus carriers
    // ------------------------------------------------------------
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [7:0] data;
        logic       addr_first;
        logic       addr_second;
        logic       wr;
        logic       rd;
        logic       bus_reset;
    } sbc_bus_t;

    typedef struct packed {
        logic [7:0] data;
        logic       wr;
        logic       rd;
    } sbc_pg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_HALF = 3'h2,
        ST_SEL  = 3'h4
    } sbc_addr_st_t;

endpackage : sbc_pkg
`default_nettype wire

/* File: hw/sbc_quad_counter.sv */
// Sixteen-bit quadrature up/down counter
`timescale 1ns/100ps
`default_nettype none
module sbc_quad_counter
    import sbc_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             clear_i,
    input  wire logic             enc_a_i,
    input  wire logic             enc_b_i,
    output logic [CNT_W-1:0]      count_o
);

    logic [1:0]       cur_q;
    logic [1:0]       prev_q;
    logic [CNT_W-1:0] count_q;

    // ------------------------------------------------------------
    // Transition decode: one changed line is a count, two is noise
    // ------------------------------------------------------------
    wire changed = (cur_q != prev_q);
    wire both    = (cur_q[1] != prev_q[1]) && (cur_q[0] != prev_q[0]);
    wire move    = changed && !both; // R8
    wire up      = prev_q[1] ^ cur_q[0]; // R8

    // Sampling every core clock leaves many cycles per edge at full rate
    always_ff @(posedge core_clk_i) begin
        cur_q  <= {enc_a_i, enc_b_i}; // R10
        prev_q <= cur_q;
        if (clear_i) begin
            prev_q  <= {enc_a_i, enc_b_i};
            cur_q   <= {enc_a_i, enc_b_i};
            count_q <= '0; // R12
        end else if (move) begin
            count_q <= up ? count_q + 16'h0001 : count_q - 16'h0001; // R8 R9
        end
    end

    assign count_o = count_q;

endmodule : sbc_quad_counter
`default_nettype wire
